// ===== cpu_address_map_decoder.sv
// address map decoder, program counter wrap and mode select for the cpu core
`timescale 1ns/1ps
module cpu_address_map_decoder
  import addr_map_pkg::*;
#(
  parameter bit ROM_LARGE = 1'b0,                  // 0: 128 KB rom, 1: 256 KB rom
  parameter bit RAM_LARGE = 1'b0                   // 0: 12 KB ram, 1: 16 KB ram
) (
  input  wire logic                     core_clk_i,           // cpu clock
  input  wire logic                     reset_n_i,            // sync reset, low active
  input  wire logic                     clk_en_i,             // freezes all state when low
  // programming voltage comparator pins, asynchronous
  input  wire logic                     vpp_prog_i,           // vpp at programming level
  input  wire logic                     vpp_supply_i,         // vpp at supply level
  output logic                          mode_normal_o,        // normal operation
  output logic                          mode_flash_o,         // flash programming/erase
  output logic                          mode_fault_o,         // prohibited vpp setting
  // expansion mode control write from the cpu store path
  input  wire logic                     exp_ctrl_wr_i,        // write strobe
  input  wire logic [3:0]               exp_ctrl_wdata_i,     // new control value
  output logic [3:0]                    expansion_mode_ctrl_o, // current control value
  output logic                          bus_port_mode_o,      // bus pins in port function
  output logic                          hold_pins_ext_o,      // hold pins in bus function
  // program counter control
  input  wire logic                     pc_step_i,            // advance pc sequentially
  input  wire logic [2:0]               pc_step_len_i,        // bytes to advance
  input  wire logic                     branch_i,             // take a branch
  input  wire logic [31:0]              branch_disp_i,        // signed branch displacement
  input  wire logic                     exc_ack_i,            // exception acknowledged
  input  wire addr_map_pkg::exc_src_t   exc_src_i,            // which exception
  input  wire logic                     irq_ack_i,            // maskable irq acknowledged
  input  wire logic [5:0]               irq_idx_i,            // which maskable source
  output logic [31:0]                   pc_o,                 // program counter
  output logic                          vector_fault_o,       // undefined source code
  // instruction fetch
  input  wire logic                     fetch_req_i,          // fetch at pc_o
  output logic                          fetch_valid_o,        // fetch decode ready
  output logic [23:0]                   fetch_addr_o,         // physical fetch address
  output logic                          fetch_rom_sel_o,      // fetch from rom
  output logic                          fetch_ram_sel_o,      // fetch from ram
  output logic                          fetch_fault_o,        // fetch not allowed
  // operand access
  input  wire logic                     data_req_i,           // operand access
  input  wire logic                     data_we_i,            // 1: write
  input  wire logic [31:0]              data_base_i,          // pointer register
  input  wire logic [31:0]              data_disp_i,          // signed displacement
  output logic                          data_valid_o,         // access decode ready
  output logic [31:0]                   data_addr_o,          // effective cpu address
  output logic [23:0]                   phys_addr_o,          // physical address
  output logic                          rom_sel_o,            // rom selected
  output logic                          ram_sel_o,            // ram selected
  output logic                          pio_sel_o,            // peripheral i/o selected
  output logic                          ext_sel_o,            // external memory selected
  output logic                          mem_we_o,             // write to selected target
  output logic                          data_fault_o,         // prohibited access
  input  wire logic [31:0]              rom_rdata_i,          // rom read data
  input  wire logic [31:0]              ram_rdata_i,          // ram read data
  input  wire logic [31:0]              pio_rdata_i,          // peripheral read data
  input  wire logic [31:0]              ext_rdata_i,          // external read data
  output logic                          rdata_valid_o,        // read data returned
  output logic [31:0]                   rdata_o               // read data to cpu
);

  mode_t       mode_q;
  mode_t       mode_d;
  logic [1:0]  vpp_prog_sync_q;
  logic [1:0]  vpp_supply_sync_q;
  logic [3:0]  exp_ctrl_q;
  logic        ext_on;
  logic [23:0] pc_q;
  logic [23:0] pc_d;
  logic        vec_fault_q;
  logic [23:0] vec_addr;
  logic        vec_valid;
  logic [31:0] eff_addr;
  target_t     data_tgt;
  target_t     fetch_tgt;
  target_t     data_tgt_q;
  logic        data_valid_q;
  logic        data_we_q;
  logic [31:0] data_addr_q;
  logic [23:0] phys_addr_q;
  logic        fetch_valid_q;
  logic [23:0] fetch_addr_q;
  target_t     fetch_tgt_q;
  logic        fetch_fault_q;
  logic        rdata_valid_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_mux;

  // two-flop synchronisers for the vpp comparator pins
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      vpp_prog_sync_q   <= 2'h0;
      vpp_supply_sync_q <= 2'h0;
    end else if (clk_en_i) begin
      vpp_prog_sync_q   <= {vpp_prog_sync_q[0], vpp_prog_i};
      vpp_supply_sync_q <= {vpp_supply_sync_q[0], vpp_supply_i};
    end
  end

  // mode selection from the settled vpp level
  // vpp mode decode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RESET, MODE_NORMAL, MODE_FLASH, MODE_BAD: begin
        if (vpp_supply_sync_q[1]) begin
          mode_d = MODE_BAD;
        end else if (vpp_prog_sync_q[1]) begin
          mode_d = MODE_FLASH;
        end else begin
          mode_d = MODE_NORMAL;
        end
      end
      default: mode_d = MODE_RESET;
    endcase
  end

  // mode register; the reset state lasts one enabled edge, and the
  // outputs may read normal for two more cycles while the synchronisers fill
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mode_q <= MODE_RESET;
    end else if (clk_en_i) begin
      mode_q <= mode_d;
    end
  end

  assign mode_normal_o = (mode_q == MODE_NORMAL);
  assign mode_flash_o  = (mode_q == MODE_FLASH);
  assign mode_fault_o  = (mode_q == MODE_BAD);

  // expansion mode control, cleared by reset so the chip starts single-chip
  // pins start in port mode
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      exp_ctrl_q <= EXP_CTRL_RESET;
    end else if (clk_en_i && exp_ctrl_wr_i) begin
      exp_ctrl_q <= exp_ctrl_wdata_i;
    end
  end

  // external space opens only once an address-space code is written
  assign ext_on = (exp_ctrl_q[EXP_SPACE_LSB +: EXP_SPACE_W] != 3'h0);

  assign expansion_mode_ctrl_o = exp_ctrl_q;
  assign bus_port_mode_o       = !ext_on;
  assign hold_pins_ext_o       = exp_ctrl_q[EXP_HOLD_BIT];

  // handler address lookup; maskable ack wins over exception ack
  vector_table u_vector_table (
    .maskable_i  (irq_ack_i),
    .exc_src_i   (exc_src_i),
    .irq_idx_i   (irq_idx_i),
    .vec_addr_o  (vec_addr),
    .vec_valid_o (vec_valid)
  );

  // next pc: acknowledge, then branch, then sequential step.
  // only 24 bits are kept, so any carry or borrow out of bit 23
  // simply falls off and the program space wraps
  always_comb begin
    pc_d = pc_q;
    if ((exc_ack_i || irq_ack_i) && vec_valid) begin
      pc_d = vec_addr;
    end else if (branch_i) begin
      pc_d = pc_q + branch_disp_i[23:0];
    end else if (pc_step_i) begin
      pc_d = pc_q + {21'h000000, pc_step_len_i};
    end
  end

  // program counter, starts at the reset entry in internal rom
  // fetch from reset entry
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pc_q <= VEC_RESET;
    end else if (clk_en_i) begin
      pc_q <= pc_d;
    end
  end

  // an acknowledge with an undefined source does not load pc (a branch or step still applies) and flags it
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      vec_fault_q <= 1'b0;
    end else if (clk_en_i) begin
      vec_fault_q <= (exc_ack_i || irq_ack_i) && !vec_valid;
    end
  end

  // upper pc byte is always zero
  // program space limited to 16 MB
  assign pc_o           = {8'h00, pc_q};
  assign vector_fault_o = vec_fault_q;

  // fetch decode; the peripheral area is never a fetch target, so a
  // branch there is caught as a fault rather than reading registers
  // ignore upper address byte
  assign fetch_tgt = decode_target(pc_q, ROM_LARGE, RAM_LARGE, ext_on);

  // registered fetch result
  // no fetch from peripheral area
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fetch_valid_q <= 1'b0;
      fetch_addr_q  <= 24'h000000;
      fetch_tgt_q   <= TGT_NONE;
      fetch_fault_q <= 1'b0;
    end else if (clk_en_i) begin
      fetch_valid_q <= fetch_req_i;
      if (fetch_req_i) begin
        fetch_addr_q  <= pc_q;
        fetch_tgt_q   <= fetch_tgt;
        fetch_fault_q <= (fetch_tgt == TGT_PIO) || (fetch_tgt == TGT_NONE);
      end
    end
  end

  assign fetch_valid_o   = fetch_valid_q;
  assign fetch_addr_o    = fetch_addr_q;
  assign fetch_rom_sel_o = fetch_valid_q && (fetch_tgt_q == TGT_ROM);
  assign fetch_ram_sel_o = fetch_valid_q && (fetch_tgt_q == TGT_RAM);
  assign fetch_fault_o   = fetch_valid_q && fetch_fault_q;

  // effective operand address; a 32-bit sum drops its carry so the
  // data space wraps from the top back to zero
  // drop overflow past 32 bits
  assign eff_addr = data_base_i + data_disp_i;

  // operand decode on the low 24 bits only
  // 256 images of the physical space
  assign data_tgt = decode_target(eff_addr[23:0], ROM_LARGE, RAM_LARGE, ext_on);

  // registered operand decode
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      data_valid_q <= 1'b0;
      data_we_q    <= 1'b0;
      data_addr_q  <= 32'h00000000;
      phys_addr_q  <= 24'h000000;
      data_tgt_q   <= TGT_NONE;
    end else if (clk_en_i) begin
      data_valid_q <= data_req_i;
      if (data_req_i) begin
        data_we_q   <= data_we_i;
        data_addr_q <= eff_addr;
        data_tgt_q  <= data_tgt;
        if (data_tgt == TGT_PIO) begin
          phys_addr_q <= pio_fold(eff_addr[23:0]);
        end else begin
          phys_addr_q <= eff_addr[23:0];
        end
      end
    end
  end

  // selects and write enable only while the decode result is live
  // prohibited access selects nothing
  assign data_valid_o = data_valid_q;
  assign data_addr_o  = data_addr_q;
  assign phys_addr_o  = phys_addr_q;
  assign rom_sel_o    = data_valid_q && (data_tgt_q == TGT_ROM);
  assign ram_sel_o    = data_valid_q && (data_tgt_q == TGT_RAM);
  assign pio_sel_o    = data_valid_q && (data_tgt_q == TGT_PIO);
  assign ext_sel_o    = data_valid_q && (data_tgt_q == TGT_EXT);
  assign data_fault_o = data_valid_q && (data_tgt_q == TGT_NONE);
  assign mem_we_o     = data_valid_q && data_we_q && (data_tgt_q != TGT_NONE);

  // read return mux; targets answer combinationally in the select cycle
  // prohibited read returns zero
  always_comb begin
    rdata_mux = 32'h00000000;
    if (data_tgt_q == TGT_ROM) begin
      rdata_mux = rom_rdata_i;
    end else if (data_tgt_q == TGT_RAM) begin
      rdata_mux = ram_rdata_i;
    end else if (data_tgt_q == TGT_PIO) begin
      rdata_mux = pio_rdata_i;
    end else if (data_tgt_q == TGT_EXT) begin
      rdata_mux = ext_rdata_i;
    end
  end

  // read data is held until the next read returns
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rdata_valid_q <= 1'b0;
      rdata_q       <= 32'h00000000;
    end else if (clk_en_i) begin
      rdata_valid_q <= data_valid_q && !data_we_q;
      if (data_valid_q && !data_we_q) begin
        rdata_q <= rdata_mux;
      end
    end
  end

  assign rdata_valid_o = rdata_valid_q;
  assign rdata_o       = rdata_q;

endmodule

// ===== addr_map_pkg.sv
// constants, types and decode functions for the cpu address map decoder
package addr_map_pkg;

  // physical space is the low 24 bits of every cpu address
  localparam int unsigned PHYS_W = 24;
  localparam int unsigned ADDR_W = 32;

  // internal rom area and the two rom build sizes
  localparam logic [23:0] ROM_AREA_END   = 24'h100000;
  localparam logic [23:0] ROM_SMALL_END  = 24'h020000;
  localparam logic [23:0] ROM_LARGE_END  = 24'h040000;

  // internal ram area and the two ram build sizes
  localparam logic [23:0] RAM_AREA_BASE  = 24'hFF8000;
  localparam logic [23:0] RAM_SMALL_BASE = 24'hFFC000;
  localparam logic [23:0] RAM_LARGE_BASE = 24'hFFB000;

  // peripheral i/o area, 4 KB reserved, 1 KB physical window
  localparam logic [23:0] PIO_BASE       = 24'hFFF000;
  localparam logic [23:0] PIO_WIN_MASK   = 24'h0003FF;

  // fixed handler addresses
  localparam logic [23:0] VEC_RESET      = 24'h000000;
  localparam logic [23:0] VEC_NMI        = 24'h000010;
  localparam logic [23:0] VEC_WDT        = 24'h000020;
  localparam logic [23:0] VEC_TRAP0      = 24'h000040;
  localparam logic [23:0] VEC_TRAP1      = 24'h000050;
  localparam logic [23:0] VEC_ILLEGAL_OPCODE_EXC      = 24'h000060;
  localparam logic [23:0] VEC_MASK_BASE  = 24'h000080;
  localparam logic [23:0] VEC_MASK_LAST  = 24'h000330;
  localparam int unsigned VEC_SLOT_SHIFT = 4;
  localparam logic [5:0]  MASK_SRC_LAST  = 6'h2B;

  // expansion mode control field layout
  localparam int unsigned EXP_SPACE_LSB  = 0;
  localparam int unsigned EXP_SPACE_W    = 3;
  localparam int unsigned EXP_HOLD_BIT   = 3;
  localparam logic [3:0]  EXP_CTRL_RESET = 4'h0;

  // non-maskable interrupt and exception sources
  typedef enum logic [2:0] {
    EXC_RESET = 3'h0,
    EXC_NMI   = 3'h1,
    EXC_WDT   = 3'h2,
    EXC_TRAP0 = 3'h3,
    EXC_TRAP1 = 3'h4,
    EXC_ILLEGAL_OPCODE_EXC = 3'h5
  } exc_src_t;

  // decode targets, one-hot
  typedef enum logic [4:0] {
    TGT_NONE = 5'h01,
    TGT_ROM  = 5'h02,
    TGT_RAM  = 5'h04,
    TGT_PIO  = 5'h08,
    TGT_EXT  = 5'h10
  } target_t;

  // operating mode states, one-hot
  typedef enum logic [3:0] {
    MODE_RESET  = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_FLASH  = 4'h4,
    MODE_BAD    = 4'h8
  } mode_t;

  // map a 24-bit physical address onto its target
  function automatic target_t decode_target(input logic [23:0] a,
                                            input logic        rom_large,
                                            input logic        ram_large,
                                            input logic        ext_on);
    logic [23:0] rom_end;
    logic [23:0] ram_base;
    rom_end  = rom_large ? ROM_LARGE_END : ROM_SMALL_END;
    ram_base = ram_large ? RAM_LARGE_BASE : RAM_SMALL_BASE;
    if (a < ROM_AREA_END) begin
      decode_target = (a < rom_end) ? TGT_ROM : TGT_NONE;
    end else if (a >= PIO_BASE) begin
      decode_target = TGT_PIO;
    end else if (a >= RAM_AREA_BASE) begin
      decode_target = (a >= ram_base) ? TGT_RAM : TGT_NONE;
    end else begin
      decode_target = ext_on ? TGT_EXT : TGT_NONE;
    end
  endfunction

  // fold the upper mirrors of the peripheral area onto the window
  function automatic logic [23:0] pio_fold(input logic [23:0] a);
    pio_fold = PIO_BASE | (a & PIO_WIN_MASK);
  endfunction

endpackage

// ===== vector_table.sv
// handler address lookup for exceptions and maskable interrupts
`timescale 1ns/1ps
module vector_table
  import addr_map_pkg::*;
(
  input  wire logic                  maskable_i,  // 1: irq_idx_i, 0: exc_src_i
  input  wire addr_map_pkg::exc_src_t exc_src_i,  // fixed source code
  input  wire logic [5:0]            irq_idx_i,   // maskable slot index
  output logic [23:0]                vec_addr_o,  // handler address
  output logic                       vec_valid_o  // source code is defined
);

  logic [23:0] slot_ofs;

  // maskable slots are 16 bytes apart from the first maskable vector
  assign slot_ofs = {18'h00000, irq_idx_i} << VEC_SLOT_SHIFT;

  // plain lookup, no storage
  always_comb begin
    vec_addr_o  = VEC_RESET;
    vec_valid_o = 1'b1;
    if (maskable_i) begin
      vec_addr_o  = VEC_MASK_BASE + slot_ofs;
      vec_valid_o = (irq_idx_i <= MASK_SRC_LAST);
    end else begin
      case (exc_src_i)
        EXC_RESET: vec_addr_o = VEC_RESET;
        EXC_NMI:   vec_addr_o = VEC_NMI;
        EXC_WDT:   vec_addr_o = VEC_WDT;
        EXC_TRAP0: vec_addr_o = VEC_TRAP0;
        EXC_TRAP1: vec_addr_o = VEC_TRAP1;
        EXC_ILLEGAL_OPCODE_EXC: vec_addr_o = VEC_ILLEGAL_OPCODE_EXC;
        default:   vec_valid_o = 1'b0;
      endcase
    end
  end

endmodule

// ===== cpu_address_map_decoder_assertions.sv
// concurrent checks on the address map decoder ports
`timescale 1ns/1ps
module cpu_address_map_decoder_assertions
  import addr_map_pkg::*;
#(
  parameter bit ROM_LARGE = 1'b0,
  parameter bit RAM_LARGE = 1'b0
) (
  input logic        core_clk_i,
  input logic        reset_n_i,
  input logic        clk_en_i,
  input logic        bus_port_mode_o,
  input logic [31:0] pc_o,
  input logic        fetch_req_i,
  input logic        fetch_valid_o,
  input logic [23:0] fetch_addr_o,
  input logic        fetch_rom_sel_o,
  input logic        fetch_fault_o,
  input logic        data_req_i,
  input logic        data_we_i,
  input logic [31:0] data_base_i,
  input logic [31:0] data_disp_i,
  input logic        data_valid_o,
  input logic [31:0] data_addr_o,
  input logic [23:0] phys_addr_o,
  input logic        rom_sel_o,
  input logic        ram_sel_o,
  input logic        pio_sel_o,
  input logic        ext_sel_o,
  input logic        mem_we_o,
  input logic        data_fault_o,
  input logic        rdata_valid_o,
  input logic [31:0] rdata_o,
  input logic        irq_ack_i,
  input logic [5:0]  irq_idx_i
);
  localparam logic [23:0] ROM_END  = ROM_LARGE ? ROM_LARGE_END : ROM_SMALL_END;
  localparam logic [23:0] RAM_BASE = RAM_LARGE ? RAM_LARGE_BASE : RAM_SMALL_BASE;
  logic [31:0] eff_q;

  // a 32-bit sum drops the overflow, as the data space must
  always_ff @(posedge core_clk_i) begin
    eff_q <= data_base_i + data_disp_i;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_reset_state: assert property (
    $rose(reset_n_i) |-> bus_port_mode_o && pc_o == 32'h0)
    else $error("bus pins or pc wrong after reset");
  a_pc_upper_zero: assert property (
    pc_o[31:24] == 8'h00)
    else $error("pc upper byte not zero");
  a_fetch_at_pc: assert property (
    clk_en_i && fetch_req_i |=> fetch_valid_o && {8'h00, fetch_addr_o} == $past(pc_o))
    else $error("fetch address not the pc");
  a_fetch_pio_fault: assert property (
    fetch_valid_o && fetch_addr_o >= PIO_BASE |-> fetch_fault_o && !fetch_rom_sel_o)
    else $error("fetch from peripheral area allowed");
  a_data_wrap: assert property (
    clk_en_i && data_req_i |=> data_valid_o && data_addr_o == eff_q)
    else $error("operand address wrong");
  a_image_low_bits: assert property (
    data_valid_o && !pio_sel_o |-> phys_addr_o == data_addr_o[23:0])
    else $error("physical address not low 24 bits");
  a_pio_window: assert property (
    pio_sel_o |-> phys_addr_o[23:10] == 14'h3FFC && data_addr_o[23:12] == 12'hFFF)
    else $error("peripheral window fold wrong");
  a_fault_no_sel: assert property (
    data_fault_o |-> !(rom_sel_o || ram_sel_o || pio_sel_o || ext_sel_o || mem_we_o))
    else $error("prohibited access selected a target");
  a_fault_read_zero: assert property (
    clk_en_i && data_fault_o && !$past(data_we_i) |=> rdata_valid_o && rdata_o == 32'h0)
    else $error("prohibited read not zero");
  a_irq_vector: assert property (
    clk_en_i && irq_ack_i && irq_idx_i <= 6'h2B
      |=> pc_o == 32'h80 + {22'h0, $past(irq_idx_i), 4'h0})
    else $error("maskable vector wrong");
  a_rom_limit: assert property (
    data_valid_o && phys_addr_o < ROM_AREA_END |-> rom_sel_o == (phys_addr_o < ROM_END))
    else $error("rom limit wrong");
  a_ram_base: assert property (
    data_valid_o && phys_addr_o >= RAM_AREA_BASE && phys_addr_o < PIO_BASE
      |-> ram_sel_o == (phys_addr_o >= RAM_BASE))
    else $error("ram base wrong");

  c_irq: cover property (irq_ack_i);
  c_fault: cover property (data_fault_o);
  c_pio: cover property (pio_sel_o);
endmodule

bind cpu_address_map_decoder cpu_address_map_decoder_assertions
  #(.ROM_LARGE(ROM_LARGE), .RAM_LARGE(RAM_LARGE)) u_chk (.*);

// ===== mem_model.sv
// read data model for rom, ram, peripherals and external memory
`timescale 1ns/1ps
module mem_model (
  input  wire logic [23:0] addr_i,      // physical address
  output logic      [31:0] rom_rdata_o, // rom data
  output logic      [31:0] ram_rdata_o, // ram data
  output logic      [31:0] pio_rdata_o, // peripheral data
  output logic      [31:0] ext_rdata_o  // external data
);
  // each target marks its data, so a wrong select shows in the read value;
  // the data follows the address and never holds a stale word
  assign rom_rdata_o = {8'h02, addr_i};
  assign ram_rdata_o = {8'h04, addr_i};
  assign pio_rdata_o = {8'h08, addr_i};
  assign ext_rdata_o = {8'h10, addr_i};
endmodule

// ===== tb.sv
// self-checking bench for the address map decoder
`timescale 1ns/1ps
module tb;
  import addr_map_pkg::*;
  logic core_clk_i, reset_n_i, clk_en_i, vpp_prog_i, vpp_supply_i, exp_ctrl_wr_i, pc_step_i;
  logic branch_i, exc_ack_i, irq_ack_i, fetch_req_i, data_req_i, data_we_i;
  logic mode_normal_o, mode_flash_o, mode_fault_o, bus_port_mode_o, hold_pins_ext_o;
  logic vector_fault_o, fetch_valid_o, fetch_rom_sel_o, fetch_ram_sel_o, fetch_fault_o;
  logic data_valid_o, rom_sel_o, ram_sel_o, pio_sel_o, ext_sel_o, mem_we_o, data_fault_o;
  logic rdata_valid_o;
  logic [3:0]  exp_ctrl_wdata_i, expansion_mode_ctrl_o;
  logic [2:0]  pc_step_len_i;
  logic [5:0]  irq_idx_i;
  exc_src_t    exc_src_i;
  logic [31:0] branch_disp_i, data_base_i, data_disp_i, pc_o, data_addr_o, rdata_o;
  logic [31:0] rom_rdata_i, ram_rdata_i, pio_rdata_i, ext_rdata_i;
  logic [23:0] fetch_addr_o, phys_addr_o;
  int          n_errors, checks, cyc;

  cpu_address_map_decoder #(.ROM_LARGE(1'b0), .RAM_LARGE(1'b0)) dut (.*);
  mem_model u_mem (.addr_i(phys_addr_o), .rom_rdata_o(rom_rdata_i), .ram_rdata_o(ram_rdata_i),
                   .pio_rdata_o(pio_rdata_i), .ext_rdata_o(ext_rdata_i));

  // 40 ns period, 25 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // the whole run needs about 115 cycles, so this only trips on a hang
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("FAIL timeout");
      conclude();
    end
  end

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one fetch at the current pc; sel is the expected {rom, ram, fault}
  task automatic fetch(input logic [23:0] a, input logic [2:0] sel);
    fetch_req_i = 1'b1;
    tick();
    fetch_req_i = 1'b0;
    chk("fetch addr", {8'h00, a}, {8'h00, fetch_addr_o});
    chk("fetch sel", {1'b1, sel},
        {fetch_valid_o, fetch_rom_sel_o, fetch_ram_sel_o, fetch_fault_o});
  endtask

  // one operand access; reads also judge the returned word
  task automatic acc(input logic we, input logic [31:0] b, input logic [31:0] d,
                     input target_t t, input logic [23:0] pa);
    data_we_i = we;
    data_base_i = b;
    data_disp_i = d;
    data_req_i = 1'b1;
    tick();
    data_req_i = 1'b0;
    chk("data addr", b + d, data_addr_o);
    chk("phys addr", {8'h00, pa}, {8'h00, phys_addr_o});
    chk("target", {1'b1, t},
        {data_valid_o, ext_sel_o, pio_sel_o, ram_sel_o, rom_sel_o, data_fault_o});
    chk("write en", {31'h0, we && t != TGT_NONE}, {31'h0, mem_we_o});
    // an idle edge after every access keeps the request strobe from
    // being lowered and raised again in one time step
    tick();
    chk("read valid", {31'h0, !we}, {31'h0, rdata_valid_o});
    if (!we) begin
      chk("read data", (t == TGT_NONE) ? 32'h0 : {3'h0, t, pa}, rdata_o);
    end
  endtask

  task automatic t_mode();
    for (int k = 3; k >= 0; k--) begin
      {vpp_supply_i, vpp_prog_i} = k[1:0];
      repeat (4) tick();
      chk("mode", (k == 0) ? 3'b100 : (k == 1) ? 3'b010 : 3'b001,
          {mode_normal_o, mode_flash_o, mode_fault_o});
    end
    $display("test mode done");
  endtask

  task automatic t_vectors();
    logic [23:0] vt [6] = '{24'h0, 24'h10, 24'h20, 24'h40, 24'h50, 24'h60};
    exc_ack_i = 1'b1;
    for (int s = 0; s < 6; s++) begin
      exc_src_i = exc_src_t'(s);
      tick();
      chk("exc vector", {8'h00, vt[s]}, pc_o);
    end
    exc_src_i = exc_src_t'(3'h6);
    tick();
    exc_ack_i = 1'b0;
    chk("exc refused", 32'h1, {31'h0, vector_fault_o});
    // back to back acks walk every maskable slot, then one past the last
    irq_ack_i = 1'b1;
    for (int i = 0; i < 45; i++) begin
      irq_idx_i = 6'(i);
      tick();
      if (i < 44) chk("irq vector", 32'h80 + 32'(i) * 32'h10, pc_o);
    end
    irq_ack_i = 1'b0;
    chk("irq refused", {31'h0, 1'b1}, {31'h0, vector_fault_o});
    chk("pc kept", 32'h330, pc_o);
    $display("test vectors done");
  endtask

  task automatic t_pc();
    exc_src_i = EXC_RESET;
    exc_ack_i = 1'b1;
    tick();
    exc_ack_i = 1'b0;
    chk("reset entry", 32'h0, pc_o);
    branch_disp_i = 32'hFFFF_EFF0;
    branch_i = 1'b1;
    tick();
    branch_i = 1'b0;
    chk("pc borrow", 32'h00FF_EFF0, pc_o);
    fetch(24'hFFEFF0, 3'b010);
    branch_disp_i = 32'h1000;
    branch_i = 1'b1;
    tick();
    branch_i = 1'b0;
    // software never branches here; this only proves the fetch is refused
    fetch(24'hFFFFF0, 3'b001);
    branch_disp_i = 32'h20;
    branch_i = 1'b1;
    clk_en_i = 1'b0;
    tick();
    chk("frozen pc", 32'h00FF_FFF0, pc_o);
    clk_en_i = 1'b1;
    tick();
    branch_i = 1'b0;
    chk("pc carry", 32'h10, pc_o);
    pc_step_len_i = 3'h4;
    pc_step_i = 1'b1;
    tick();
    pc_step_i = 1'b0;
    fetch(24'h000014, 3'b100);
    $display("test pc done");
  endtask

  task automatic t_data();
    acc(1'b0, 32'hFFFF_FFF0, 32'h20, TGT_ROM, 24'h000010);
    acc(1'b0, 32'h7F00_0100, 32'h0, TGT_ROM, 24'h000100);
    acc(1'b0, 32'h0001_FFFC, 32'h0, TGT_ROM, 24'h01FFFC);
    acc(1'b1, 32'h0002_0000, 32'h0, TGT_NONE, 24'h020000);
    acc(1'b0, 32'h000F_FFFC, 32'h0, TGT_NONE, 24'h0FFFFC);
    acc(1'b0, 32'h00FF_BFFC, 32'h0, TGT_NONE, 24'hFFBFFC);
    acc(1'b1, 32'h00FF_C000, 32'h0, TGT_RAM, 24'hFFC000);
    acc(1'b0, 32'h01FF_EFFC, 32'h0, TGT_RAM, 24'hFFEFFC);
    acc(1'b0, 32'h00FF_F7F0, 32'h0, TGT_PIO, 24'hFFF3F0);
    acc(1'b0, 32'h0010_0000, 32'h0, TGT_NONE, 24'h100000);
    exp_ctrl_wdata_i = 4'hB;
    exp_ctrl_wr_i = 1'b1;
    tick();
    exp_ctrl_wr_i = 1'b0;
    chk("exp ctrl", 32'hB, {28'h0, expansion_mode_ctrl_o});
    chk("hold pins", 32'h1, {31'h0, hold_pins_ext_o});
    chk("port mode", 32'h0, {31'h0, bus_port_mode_o});
    acc(1'b0, 32'h0010_0000, 32'h0, TGT_EXT, 24'h100000);
    acc(1'b1, 32'h80FF_7FF0, 32'hC, TGT_EXT, 24'hFF7FFC);
    $display("test data done");
  endtask

  initial begin
    {reset_n_i, vpp_prog_i, vpp_supply_i, exp_ctrl_wr_i, exp_ctrl_wdata_i, pc_step_i} = '0;
    {pc_step_len_i, branch_i, branch_disp_i, exc_ack_i, irq_ack_i, irq_idx_i} = '0;
    {fetch_req_i, data_req_i, data_we_i, data_base_i, data_disp_i} = '0;
    exc_src_i = EXC_RESET;
    clk_en_i = 1'b1;
    repeat (12) tick();
    reset_n_i = 1'b1;
    tick();
    chk("pc at reset", 32'h0, pc_o);
    chk("port mode", 32'h1, {31'h0, bus_port_mode_o});
    t_mode();
    t_vectors();
    t_pc();
    t_data();
    conclude();
  end
endmodule
